// file: hdl/rss_pkg.sv
package rss_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int MEM_DEPTH = 24;
  localparam logic [4:0] MEM_DEPTH_PTR = 5'h18;
  localparam logic [4:0] LAST_ADDR = 5'h17;
  localparam int NUM_STROBES = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [4:0] PTR_RESET = 5'h00;

  // ****************************************************************
  // Full opcodes
  // ****************************************************************
  localparam logic [7:0] OP_WAIT_CMP = 8'hB8;
  localparam logic [7:0] OP_IRQ = 8'hB9;
  localparam logic [7:0] OP_LABEL = 8'hBA;
  localparam logic [7:0] OP_WAIT_X = 8'hBB;
  localparam logic [7:0] OP_RAND = 8'hBC;
  localparam logic [7:0] OP_Y_INC = 8'hBD;
  localparam logic [7:0] OP_Y_DEC = 8'hBE;
  localparam logic [7:0] OP_Z_DEC = 8'hBF;
  localparam logic [7:0] OP_NOP = 8'hC0;
  localparam logic [7:0] OP_STOP = 8'hDF;

  // ****************************************************************
  // Opcode prefixes and fields
  // ****************************************************************
  localparam logic [2:0] PFX_WAIT_W = 3'h4;
  localparam logic [3:0] PFX_REPEAT = 4'hA;
  localparam logic [4:0] PFX_SATINC = 5'h16;
  localparam logic [2:0] PFX_STROBE = 3'h6;
  localparam int NEG_BIT = 3;
  localparam logic [5:0] WAIT_W_ZERO_COUNT = 6'h20;

  // ****************************************************************
  // Deferred strobe codes (low five opcode bits)
  // ****************************************************************
  localparam logic [4:0] STRB_TX_CAL = 5'h01;
  localparam logic [4:0] STRB_RX_ON = 5'h02;
  localparam logic [4:0] STRB_TX_ON = 5'h03;
  localparam logic [4:0] STRB_TX_CCA = 5'h04;
  localparam logic [4:0] STRB_RF_OFF = 5'h05;

  // ****************************************************************
  // Condition codes
  // ****************************************************************
  localparam logic [2:0] COND_CCA = 3'h0;
  localparam logic [2:0] COND_SFD = 3'h1;
  localparam logic [2:0] COND_CPU = 3'h2;
  localparam logic [2:0] COND_PC_END = 3'h3;
  localparam logic [2:0] COND_X_ZERO = 3'h4;
  localparam logic [2:0] COND_Y_ZERO = 3'h5;
  localparam logic [2:0] COND_Z_ZERO = 3'h6;

  typedef enum logic [2:0] {
    RSS_IDLE, RSS_RUN, RSS_WAIT_OVF, RSS_WAIT_X, RSS_WAIT_CMP, RSS_WAIT_ACK
  } rss_state_e;

endpackage

// file: hdl/rss_cond_sel.sv
`timescale 1ns/1ps
`default_nettype none
module rss_cond_sel (
  input wire logic [2:0] cond_code,
  input wire logic negate,
  input wire logic cca,
  input wire logic sfd,
  input wire logic cpu_condition_bit,
  input wire logic [4:0] pc,
  input wire logic [7:0] x_register,
  input wire logic [7:0] y_register,
  input wire logic [7:0] z_register,
  output logic taken
);

  // ****************************************************************
  // Condition decode
  // ****************************************************************
  function automatic logic cond_value(input logic [2:0] code, input logic c_cca,
                                      input logic c_sfd, input logic c_cpu,
                                      input logic [4:0] c_pc, input logic [7:0] c_x,
                                      input logic [7:0] c_y, input logic [7:0] c_z);
    logic v;
    v = 1'b0;
    case (code)
      rss_pkg::COND_CCA: v = c_cca;
      rss_pkg::COND_SFD: v = c_sfd;
      rss_pkg::COND_CPU: v = c_cpu;
      rss_pkg::COND_PC_END: v = (c_pc == rss_pkg::LAST_ADDR);
      rss_pkg::COND_X_ZERO: v = (c_x == rss_pkg::DATA_RESET);
      rss_pkg::COND_Y_ZERO: v = (c_y == rss_pkg::DATA_RESET);
      rss_pkg::COND_Z_ZERO: v = (c_z == rss_pkg::DATA_RESET);
      default: v = 1'b0; // Unused code never holds
    endcase
    return v;
  endfunction

  wire logic raw_cond;
  assign raw_cond = cond_value(cond_code, cca, sfd, cpu_condition_bit, pc,
                               x_register, y_register, z_register);
  assign taken = raw_cond ^ negate;

endmodule
`default_nettype wire

// file: hdl/rss_strobe_port.sv
`timescale 1ns/1ps
`default_nettype none
module rss_strobe_port (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic issue,
  input wire logic [4:0] strobe_code,
  input wire logic radio_ack,
  output logic [rss_pkg::NUM_STROBES-1:0] strobe_out,
  output logic busy,
  output logic done
);

  // ****************************************************************
  // One-hot strobe decode, code 1 maps to bit 0
  // ****************************************************************
  wire logic [rss_pkg::NUM_STROBES-1:0] next_strobe;
  genvar gi;
  generate
    for (gi = 0; gi < rss_pkg::NUM_STROBES; gi = gi + 1) begin : g_dec
      assign next_strobe[gi] = issue && (strobe_code == 5'(gi + 1));
    end
  endgenerate

  assign done = busy && radio_ack;

  // Strobe is a one-cycle pulse; busy holds until the radio answers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_out <= '0;
      busy <= 1'b0;
    end else begin
      strobe_out <= next_strobe;
      busy <= issue | (busy & ~radio_ack);
    end
  end

endmodule
`default_nettype wire

// file: hdl/rss_exec.sv
// Overview of operation
// - Y increment wraps FF to 00
// - Saturating increment sets Y to min(Y+1,M)
// - Random load fills low Y bits, clears rest
// - Back-to-back random loads may repeat value
// - Signal instruction sets program irq flag
// - Wait-on-X decrements X per overflow, then advances
// - Overflow waits completing set wait-done flag
// - Immediate wait counts W overflows, zero means 32
// - Compare wait stalls until next compare event
// - Label records following address as loop start
// - Label in last slot records own PC
// - Single loop start, new label overwrites
// - Repeat jumps to label if condition true
// - Condition codes select CCA, SFD, CPU, PC, zeros
// - Negate bit inverts selected condition
// - Skip adds S+1 when true, else one
// - Stop halts, clears memory, label, PC, pointer
// - Deferred strobes stall until radio acknowledges
// - RX-on drives dedicated RX enable strobe output
`timescale 1ns/1ps
`default_nettype none
module rss_exec (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_wr_en,
  input wire logic [7:0] instr_wr_data,
  input wire logic start_exec,
  input wire logic x_wr_en,
  input wire logic y_wr_en,
  input wire logic z_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic cpu_condition_bit,
  input wire logic [7:0] random_source_out,
  input wire logic mac_overflow,
  input wire logic mac_compare,
  input wire logic cca,
  input wire logic sfd,
  input wire logic radio_ack,
  input wire logic irq_flag_clear,
  input wire logic wait_flag_clear,
  input wire logic stop_flag_clear,
  output logic tx_calibrate_strobe,
  output logic rx_enable_strobe_out,
  output logic tx_on_strobe,
  output logic tx_on_if_clear_strobe,
  output logic radio_off_strobe,
  output logic program_irq_flag,
  output logic wait_done_flag,
  output logic program_stop_flag,
  output logic running,
  output logic [4:0] pc,
  output logic [4:0] write_ptr,
  output logic [7:0] current_instr,
  output logic [7:0] x_register,
  output logic [7:0] y_register,
  output logic [7:0] z_register
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] imem [rss_pkg::MEM_DEPTH];
  rss_pkg::rss_state_e state;
  rss_pkg::rss_state_e next_state;
  logic [4:0] loop_start;
  logic loop_valid;
  logic [5:0] wait_cnt;
  logic [4:0] next_pc;
  logic [4:0] next_loop_start;
  logic next_loop_valid;
  logic [5:0] next_wait_cnt;
  logic [7:0] next_x;
  logic [7:0] next_y;
  logic [7:0] next_z;
  logic set_irq;
  logic set_wait;
  logic set_stop;
  logic clear_mem;
  logic strobe_issue;
  logic step;
  logic [5:0] target;

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  wire logic [7:0] instr;
  wire logic is_skip;
  wire logic is_wait_w;
  wire logic is_repeat;
  wire logic is_satinc;
  wire logic is_strobe;
  wire logic cond_taken;
  wire logic [5:0] pc_plus1;
  wire logic [5:0] pc_skip;
  wire logic [5:0] wait_w_count;
  wire logic [8:0] y_plus;
  wire logic [8:0] sat_limit;
  wire logic [7:0] sat_y;
  wire logic [7:0] rand_shift;
  wire logic [7:0] rand_mask;
  wire logic load_ok;
  wire logic [4:0] strobe_vec;
  wire logic strobe_busy;
  wire logic strobe_done;

  // Memory read is asynchronous from flops, so PC changes take effect at once
  assign instr = imem[pc];
  assign is_skip = ~instr[7];
  assign is_wait_w = (instr[7:5] == rss_pkg::PFX_WAIT_W);
  assign is_repeat = (instr[7:4] == rss_pkg::PFX_REPEAT);
  assign is_satinc = (instr[7:3] == rss_pkg::PFX_SATINC);
  // Only the five deferred strobes are executed; other strobe codes act as no-ops, except code 1F, which is the stop opcode
  assign is_strobe = (instr[7:5] == rss_pkg::PFX_STROBE) &&
                     (instr[4:0] >= rss_pkg::STRB_TX_CAL) &&
                     (instr[4:0] <= rss_pkg::STRB_RF_OFF);
  assign pc_plus1 = {1'b0, pc} + 6'h01;
  assign pc_skip = pc_plus1 + {3'h0, instr[6:4]};
  assign wait_w_count = (instr[4:0] == 5'h00) ? rss_pkg::WAIT_W_ZERO_COUNT
                                              : {1'b0, instr[4:0]};
  assign y_plus = {1'b0, y_register} + 9'h001;
  assign sat_limit = {6'h00, instr[2:0]};
  assign sat_y = (y_plus < sat_limit) ? y_plus[7:0] : {5'h00, instr[2:0]};
  assign rand_shift = 8'h01 << y_register[2:0];
  assign rand_mask = (y_register >= 8'h08) ? 8'hFF : (rand_shift - 8'h01);
  assign load_ok = instr_wr_en && (state == rss_pkg::RSS_IDLE) &&
                   (write_ptr < rss_pkg::MEM_DEPTH_PTR);
  assign running = (state != rss_pkg::RSS_IDLE);
  assign current_instr = running ? instr : rss_pkg::DATA_RESET;

  // ****************************************************************
  // Condition evaluation and strobe handshake
  // ****************************************************************
  rss_cond_sel u_cond (
    .cond_code(instr[2:0]),
    .negate(instr[rss_pkg::NEG_BIT]),
    .cca(cca),
    .sfd(sfd),
    .cpu_condition_bit(cpu_condition_bit),
    .pc(pc),
    .x_register(x_register),
    .y_register(y_register),
    .z_register(z_register),
    .taken(cond_taken)
  );

  rss_strobe_port u_strobe (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .issue(strobe_issue),
    .strobe_code(instr[4:0]),
    .radio_ack(radio_ack),
    .strobe_out(strobe_vec),
    .busy(strobe_busy),
    .done(strobe_done)
  );

  // Strobe vector bit is code minus one
  assign tx_calibrate_strobe = strobe_vec[0];
  assign rx_enable_strobe_out = strobe_vec[1];
  assign tx_on_strobe = strobe_vec[2];
  assign tx_on_if_clear_strobe = strobe_vec[3];
  assign radio_off_strobe = strobe_vec[4];

  // ****************************************************************
  // Sequencer next-state logic
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_loop_start = loop_start;
    next_loop_valid = loop_valid;
    next_wait_cnt = wait_cnt;
    next_x = x_register;
    next_y = y_register;
    next_z = z_register;
    set_irq = 1'b0;
    set_wait = 1'b0;
    set_stop = 1'b0;
    clear_mem = 1'b0;
    strobe_issue = 1'b0;
    step = 1'b0;
    target = pc_plus1;
    case (state)
      rss_pkg::RSS_IDLE: begin
        // CPU setup writes only while halted, so a program never races them
        if (x_wr_en) begin
          next_x = reg_wr_data;
        end
        if (y_wr_en) begin
          next_y = reg_wr_data;
        end
        if (z_wr_en) begin
          next_z = reg_wr_data;
        end
        if (start_exec && (write_ptr != rss_pkg::PTR_RESET)) begin
          next_state = rss_pkg::RSS_RUN;
          next_pc = rss_pkg::PTR_RESET;
        end
      end
      rss_pkg::RSS_RUN: begin
        if (is_skip) begin
          if (cond_taken) begin
            target = pc_skip;
          end
          step = 1'b1;
        end else if (is_wait_w) begin
          next_wait_cnt = wait_w_count;
          next_state = rss_pkg::RSS_WAIT_OVF;
        end else if (is_repeat) begin
          if (cond_taken && loop_valid) begin
            target = {1'b0, loop_start};
          end
          step = 1'b1;
        end else if (is_satinc) begin
          next_y = sat_y;
          step = 1'b1;
        end else if (is_strobe) begin
          strobe_issue = 1'b1;
          next_state = rss_pkg::RSS_WAIT_ACK;
        end else begin
          case (instr)
            rss_pkg::OP_Y_INC: begin
              next_y = y_register + 8'h01;
              step = 1'b1;
            end
            rss_pkg::OP_Y_DEC: begin
              next_y = y_register - 8'h01;
              step = 1'b1;
            end
            rss_pkg::OP_Z_DEC: begin
              next_z = z_register - 8'h01;
              step = 1'b1;
            end
            rss_pkg::OP_RAND: begin
              next_x = random_source_out & rand_mask;
              step = 1'b1;
            end
            rss_pkg::OP_IRQ: begin
              set_irq = 1'b1;
              step = 1'b1;
            end
            rss_pkg::OP_WAIT_X: begin
              next_state = rss_pkg::RSS_WAIT_X;
            end
            rss_pkg::OP_WAIT_CMP: begin
              next_state = rss_pkg::RSS_WAIT_CMP;
            end
            rss_pkg::OP_LABEL: begin
              next_loop_start = (pc == rss_pkg::LAST_ADDR) ? pc : pc_plus1[4:0];
              next_loop_valid = 1'b1;
              step = 1'b1;
            end
            rss_pkg::OP_STOP: begin
              next_state = rss_pkg::RSS_IDLE;
              next_pc = rss_pkg::PTR_RESET;
              next_loop_valid = 1'b0;
              clear_mem = 1'b1;
              set_stop = 1'b1;
            end
            default: begin
              step = 1'b1;
            end
          endcase
        end
      end
      rss_pkg::RSS_WAIT_OVF: begin
        if (mac_overflow) begin
          next_wait_cnt = wait_cnt - 6'h01;
          if (wait_cnt == 6'h01) begin
            set_wait = 1'b1;
            step = 1'b1;
          end
        end
      end
      rss_pkg::RSS_WAIT_X: begin
        if (x_register == rss_pkg::DATA_RESET) begin
          set_wait = 1'b1;
          step = 1'b1;
        end else if (mac_overflow) begin
          next_x = x_register - 8'h01;
          if (x_register == 8'h01) begin
            set_wait = 1'b1;
            step = 1'b1;
          end
        end
      end
      rss_pkg::RSS_WAIT_CMP: begin
        if (mac_compare) begin
          step = 1'b1;
        end
      end
      rss_pkg::RSS_WAIT_ACK: begin
        if (strobe_done) begin
          step = 1'b1;
        end
      end
      default: begin
        next_state = rss_pkg::RSS_IDLE;
      end
    endcase
    // Running past the loaded program ends it, but keeps the program for a rerun
    if (step) begin
      if (target >= {1'b0, write_ptr}) begin
        next_state = rss_pkg::RSS_IDLE;
        next_pc = rss_pkg::PTR_RESET;
        set_stop = 1'b1;
      end else begin
        next_state = rss_pkg::RSS_RUN;
        next_pc = target[4:0];
      end
    end
  end

  // ****************************************************************
  // Sequencer registers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rss_pkg::RSS_IDLE;
      pc <= rss_pkg::PTR_RESET;
      loop_start <= rss_pkg::PTR_RESET;
      loop_valid <= 1'b0;
      wait_cnt <= 6'h00;
      x_register <= rss_pkg::DATA_RESET;
      y_register <= rss_pkg::DATA_RESET;
      z_register <= rss_pkg::DATA_RESET;
    end else begin
      state <= next_state;
      pc <= next_pc;
      loop_start <= next_loop_start;
      loop_valid <= next_loop_valid;
      wait_cnt <= next_wait_cnt;
      x_register <= next_x;
      y_register <= next_y;
      z_register <= next_z;
    end
  end

  // Flags: a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_irq_flag <= 1'b0;
      wait_done_flag <= 1'b0;
      program_stop_flag <= 1'b0;
    end else begin
      program_irq_flag <= set_irq | (program_irq_flag & ~irq_flag_clear);
      wait_done_flag <= set_wait | (wait_done_flag & ~wait_flag_clear);
      program_stop_flag <= set_stop | (program_stop_flag & ~stop_flag_clear);
    end
  end

  // ****************************************************************
  // Instruction memory
  // ****************************************************************
  // Cleared as a whole by the stop instruction; loaded only while halted
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_ptr <= rss_pkg::PTR_RESET;
      for (int i = 0; i < rss_pkg::MEM_DEPTH; i++) begin
        imem[i] <= rss_pkg::DATA_RESET;
      end
    end else if (clear_mem) begin
      write_ptr <= rss_pkg::PTR_RESET;
      for (int i = 0; i < rss_pkg::MEM_DEPTH; i++) begin
        imem[i] <= rss_pkg::DATA_RESET;
      end
    end else if (load_ok) begin
      imem[write_ptr] <= instr_wr_data;
      write_ptr <= write_ptr + 5'h01;
    end
  end

endmodule
`default_nettype wire

// file: sim/rss_radio_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Radio command port model
// ****
module rss_radio_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [4:0] strobe_vec,
  input wire logic cca,
  input wire logic fast_ack,
  input wire logic [3:0] ack_delay,
  output logic radio_ack
);
  logic [3:0] cnt;
  logic pend;
  logic slow_ack;
  logic tx_active;
  logic rx_active;
  // Radio state; the slow answer comes only after the command took effect
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      pend <= 1'b0;
      slow_ack <= 1'b0;
      tx_active <= 1'b0;
      rx_active <= 1'b0;
    end else begin
      slow_ack <= 1'b0;
      if (strobe_vec[1]) rx_active <= 1'b1;
      if (strobe_vec[2] || (strobe_vec[3] && cca)) tx_active <= 1'b1;
      if (strobe_vec[4]) begin
        rx_active <= 1'b0;
        tx_active <= 1'b0;
      end
      if (|strobe_vec) begin
        pend <= 1'b1;
        cnt <= ack_delay;
      end else if (pend && cnt == 4'h0) begin
        pend <= 1'b0;
        slow_ack <= 1'b1;
      end else if (pend) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  // Prompt mode answers in the strobe cycle itself, the hardest case
  assign radio_ack = fast_ack ? |strobe_vec : slow_ack;
endmodule
`default_nettype wire

// file: sim/rss_exec_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module rss_exec_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic radio_ack,
  input wire logic mac_compare,
  input wire logic [7:0] random_source_out,
  input wire logic tx_calibrate_strobe,
  input wire logic rx_enable_strobe_out,
  input wire logic tx_on_strobe,
  input wire logic tx_on_if_clear_strobe,
  input wire logic radio_off_strobe,
  input wire logic program_irq_flag,
  input wire logic program_stop_flag,
  input wire logic running,
  input wire logic [4:0] pc,
  input wire logic [4:0] write_ptr,
  input wire logic [7:0] current_instr,
  input wire logic [7:0] x_register,
  input wire logic [7:0] y_register
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic strb;
  logic [8:0] y_inc;
  logic [7:0] sat_val;
  logic [7:0] rmask;
  // Expected results; nine bits so the limit compare never wraps
  assign strb = tx_calibrate_strobe | rx_enable_strobe_out | tx_on_strobe
    | tx_on_if_clear_strobe | radio_off_strobe;
  assign y_inc = {1'b0, y_register} + 9'h001;
  assign sat_val = (y_inc < {6'h00, current_instr[2:0]}) ? y_inc[7:0]
    : {5'h00, current_instr[2:0]};
  assign rmask = (y_register > 8'h07) ? 8'hFF : ((8'h01 << y_register[2:0]) - 8'h01);
  sequence s_op(logic [7:0] op);
    running && current_instr == op;
  endsequence
  // Opcode in execution with an extra qualifier folded into one sequence
  sequence s_op_when(op, cond);
    running && current_instr == op && cond;
  endsequence
  sequence s_strobe;
    strb && !radio_ack;
  endsequence
  y_wrap_a: assert property (s_op(rss_pkg::OP_Y_INC) |=>
    y_register == $past(y_inc[7:0])) else $error("Y increment wrong");
  y_sat_a: assert property (running && current_instr[7:3] == rss_pkg::PFX_SATINC |=>
    y_register == $past(sat_val)) else $error("Saturating increment wrong");
  rand_load_a: assert property (s_op(rss_pkg::OP_RAND) |=>
    x_register == ($past(random_source_out) & $past(rmask))) else $error("Random load wrong");
  irq_set_a: assert property (s_op(rss_pkg::OP_IRQ) |=> program_irq_flag)
    else $error("Irq flag not set");
  cmp_hold_a: assert property (s_op_when(rss_pkg::OP_WAIT_CMP, !mac_compare) |=>
    $stable(pc)) else $error("Compare wait moved early");
  stop_clear_a: assert property (s_op(rss_pkg::OP_STOP) |=> !running &&
    pc == 5'h00 && write_ptr == 5'h00 && program_stop_flag) else $error("Stop incomplete");
  nop_step_a: assert property (s_op_when(rss_pkg::OP_NOP, pc + 5'h01 < write_ptr) |=>
    pc == $past(pc) + 5'h01 && $stable(x_register) && $stable(y_register))
    else $error("No-op side effect");
  strobe_hold_a: assert property (s_strobe |=> $stable(pc) && !strb)
    else $error("Strobe stall wrong");
  rx_pulse_a: assert property (s_op_when({rss_pkg::PFX_STROBE, rss_pkg::STRB_RX_ON},
    pc != $past(pc) || !$past(running)) |=> rx_enable_strobe_out) else $error("No RX strobe");
endmodule
bind rss_exec rss_exec_checker i_rss_exec_checker (.*);
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0, rst_n = 1'b0, instr_wr_en = 1'b0, start_exec = 1'b0;
  logic x_wr_en = 1'b0, y_wr_en = 1'b0, z_wr_en = 1'b0, cpu_condition_bit = 1'b0;
  logic mac_overflow = 1'b0, mac_compare = 1'b0, cca = 1'b0, sfd = 1'b0;
  logic irq_flag_clear = 1'b0, wait_flag_clear = 1'b0, stop_flag_clear = 1'b0;
  logic [7:0] instr_wr_data = 8'h00, reg_wr_data = 8'h00, random_source_out = 8'h00;
  logic radio_ack, tx_calibrate_strobe, rx_enable_strobe_out, tx_on_strobe;
  logic tx_on_if_clear_strobe, radio_off_strobe, program_irq_flag, wait_done_flag;
  logic program_stop_flag, running;
  logic [4:0] pc, write_ptr, stv;
  logic [7:0] current_instr, x_register, y_register, z_register;
  logic fast_ack = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  int bad_count = 0, checked = 0;
  int hits [5] = '{default: 0};
  // ****
  // Clock, design, radio and strobe counters
  // ****
  always #20 ref_clk = ~ref_clk;
  assign stv = {radio_off_strobe, tx_on_if_clear_strobe, tx_on_strobe,
    rx_enable_strobe_out, tx_calibrate_strobe};
  rss_exec i_rss_exec (.*);
  rss_radio_model i_rss_radio_model (.ref_clk(ref_clk), .rst_n(rst_n), .strobe_vec(stv),
    .cca(cca), .fast_ack(fast_ack), .ack_delay(ack_delay), .radio_ack(radio_ack));
  always @(posedge ref_clk) for (int i = 0; i < 5; i++) hits[i] += int'(stv[i] === 1'b1);
  // ****
  // Shared tasks
  // ****
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Registers are only written while idle
  task set_regs(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    reg_wr_data = x;
    x_wr_en = 1'b1;
    tick;
    x_wr_en = 1'b0;
    reg_wr_data = y;
    y_wr_en = 1'b1;
    tick;
    y_wr_en = 1'b0;
    reg_wr_data = z;
    z_wr_en = 1'b1;
    tick;
    z_wr_en = 1'b0;
  endtask
  // Load a program and start it; flags are cleared in the start cycle
  task automatic run(input logic [7:0] p[$]);
    foreach (p[i]) begin
      instr_wr_data = p[i];
      instr_wr_en = 1'b1;
      tick;
    end
    instr_wr_en = 1'b0;
    {start_exec, irq_flag_clear, wait_flag_clear, stop_flag_clear} = 4'hF;
    tick;
    {start_exec, irq_flag_clear, wait_flag_clear, stop_flag_clear} = 4'h0;
  endtask
  task automatic idle_wait;
    for (int n = 0; n < 300 && running !== 1'b0; n++) tick;
    check({7'h00, running}, 8'h00);
  endtask
  // ****
  // Scenarios
  // ****
  task t_yops;
    set_regs(8'h00, 8'hFF, 8'h00);
    run('{8'hBD, 8'hC0, 8'hB3, 8'hB3, 8'hB3, 8'hB3, 8'hBF, 8'hB9, 8'hDF});
    idle_wait;
    check(y_register, 8'h03);
    check(z_register, 8'hFF);
    check({7'h00, program_irq_flag}, 8'h01);
    check({2'h0, program_stop_flag, write_ptr}, 8'h20);
  endtask
  task t_rand;
    set_regs(8'hFF, 8'h03, 8'h00);
    random_source_out = 8'hFE;
    run('{8'hBC, 8'hBC, 8'hDF});
    idle_wait;
    check(x_register, 8'h06);
  endtask
  // Overflows arrive slowly; the program must hold until the last one
  task automatic t_wait(input logic [7:0] op, input int n);
    run('{op, 8'hDF});
    repeat (n) begin
      tick;
      tick;
      check({7'h00, running}, 8'h01);
      mac_overflow = 1'b1;
      tick;
      mac_overflow = 1'b0;
    end
    idle_wait;
    check({7'h00, wait_done_flag}, 8'h01);
  endtask
  task t_cmp;
    run('{8'hB8, 8'hDF});
    repeat (5) tick;
    check({7'h00, running}, 8'h01);
    mac_compare = 1'b1;
    tick;
    mac_compare = 1'b0;
    idle_wait;
  endtask
  // Second program has no label: the previous stop invalidated it
  task t_loop;
    set_regs(8'h00, 8'hFD, 8'h00);
    run('{8'hBA, 8'hBD, 8'hAD, 8'hDF});
    idle_wait;
    check(y_register, 8'h00);
    set_regs(8'h00, 8'h05, 8'h00);
    run('{8'hAD, 8'hBD, 8'hDF});
    idle_wait;
    check(y_register, 8'h06);
  endtask
  // End-of-memory and unused codes false, all others true, both polarities
  task automatic t_skip;
    {cca, sfd, cpu_condition_bit} = 3'h7;
    for (int c = 0; c < 8; c++) for (int n = 0; n < 2; n++) begin
      set_regs(8'h00, 8'h00, 8'h00);
      run('{{1'b0, 3'h1, n[0], c[2:0]}, 8'hBD, 8'hDF});
      idle_wait;
      check(y_register, {7'h00, (c == 3 || c == 7) ^ n[0]});
    end
    {cca, sfd, cpu_condition_bit} = 3'h0;
  endtask
  // Full memory: repeat from the last slot back to the label, then skip onto the stop
  task automatic t_end;
    logic [7:0] p[$];
    p = '{8'hBA, 8'h1D, 8'h1F, 8'hDF, 8'hBD};
    repeat (18) p.push_back(8'hC0);
    p.push_back(8'hA3);
    set_regs(8'h00, 8'h00, 8'h00);
    run(p);
    idle_wait;
    check(y_register, 8'h01);
    check({3'h0, write_ptr}, 8'h00);
  endtask
  task automatic t_strobe(input logic fast, input logic [3:0] dly);
    fast_ack = fast;
    ack_delay = dly;
    hits = '{default: 0};
    run('{8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hDF});
    idle_wait;
    foreach (hits[i]) check(8'(hits[i]), 8'h01);
    check({6'h00, i_rss_radio_model.rx_active, i_rss_radio_model.tx_active}, 8'h00);
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    tick;
    check({2'h0, running, write_ptr}, 8'h00);
    t_yops;
    t_rand;
    t_wait(8'h82, 2);
    t_wait(8'h80, 32);
    set_regs(8'h03, 8'h00, 8'h00);
    t_wait(8'hBB, 3);
    check(x_register, 8'h00);
    t_cmp;
    t_loop;
    t_skip;
    t_end;
    t_strobe(1'b1, 4'h0);
    t_strobe(1'b0, 4'h5);
    summarize;
  end
  initial begin
    #2000000;
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    summarize;
  end
endmodule
`default_nettype wire
